// >>> pg_rail_ctrl_checker.sv
// concurrent checks on the ports of the power-good and rail control block
// assumes a single clock domain and the synchronous active-high reset
`timescale 1ns/100ps
module pg_rail_ctrl_checker #(
  parameter int MS_TICK_CYCLES = 10
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_control_input_three,
  input wire logic i_control_input_six,
  input wire logic [3:0] i_pg_members,
  input wire logic o_sda_drive_n,
  input wire logic [3:0] o_pg_output,
  input wire logic o_termination_discharge_sel,
  input wire logic [1:0] o_aux_discharge_sel,
  input wire logic [3:0] o_aux_voltage_code,
  input wire logic o_aux_regulator_enable,
  input wire logic o_load_switch_b2_enable
);
  // ****************************************
  // serial clock quiet counter
  // ****************************************
  logic [2:0] quiet_ff;
  logic prev_scl_ff;
  // register writes land within four cycles of a clock fall, so six quiet cycles means settled
  always_ff @(posedge i_clock) begin
    prev_scl_ff <= i_scl;
    if (i_sys_rst || (i_scl != prev_scl_ff)) begin
      quiet_ff <= 3'h0;
    end else if (quiet_ff != 3'h7) begin
      quiet_ff <= quiet_ff + 3'h1;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  a_out1_member_bad: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !i_pg_members[0] |=> !o_pg_output[0]) else $error("output one good with a bad member");
  a_out3_member_fell: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $fell(i_pg_members[2]) |=> !o_pg_output[2]) else $error("output three kept good after member fell");
  a_out2_all_good: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !$past(i_sys_rst) && i_control_input_three && i_control_input_six && i_pg_members[1] |=> o_pg_output[1])
    else $error("output two not good with all members good");
  a_out4_all_good: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !$past(i_sys_rst) && (i_control_input_three & i_control_input_six & i_pg_members[3]) |=> o_pg_output[3])
    else $error("output four not good with all members good");
  a_one_rail_only: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !(o_aux_regulator_enable && o_load_switch_b2_enable)) else $error("both rail enables high");
  a_reset_outputs_clear: assert property (@(posedge i_clock)
    i_sys_rst |=> o_pg_output == 4'h0 && o_sda_drive_n && !o_aux_regulator_enable && !o_load_switch_b2_enable)
    else $error("outputs not cleared by reset");
  a_aux_fields_quiet: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    quiet_ff >= 3'h6 |-> $stable(o_aux_voltage_code) && $stable(o_aux_discharge_sel))
    else $error("aux fields moved without bus traffic");
  a_term_sel_quiet: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    quiet_ff >= 3'h6 |-> $stable(o_termination_discharge_sel)) else $error("termination select moved while idle");
endmodule
bind power_good_mask_and_rail_ctrl pg_rail_ctrl_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_pg_rail_ctrl_checker (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_control_input_three(i_control_input_three),
  .i_control_input_six(i_control_input_six), .i_pg_members(i_pg_members), .o_sda_drive_n(o_sda_drive_n),
  .o_pg_output(o_pg_output), .o_termination_discharge_sel(o_termination_discharge_sel),
  .o_aux_discharge_sel(o_aux_discharge_sel), .o_aux_voltage_code(o_aux_voltage_code),
  .o_aux_regulator_enable(o_aux_regulator_enable), .o_load_switch_b2_enable(o_load_switch_b2_enable));

// >>> pg_rail_pkg.sv
// package for the power-good mask and auxiliary rail control block
// assumes a 100 MHz system clock and factory settings held stable outside
package pg_rail_pkg;

  // ****************************************
  // register offsets on the serial bus
  // ****************************************
  localparam logic [7:0] CTL_INPUT_PG_MASK_OFS = 8'hac;
  localparam logic [7:0] TERMINATION_DISCHARGE_CTRL_OFS = 8'had;
  localparam logic [7:0] AUX_RAIL_CTRL_OFS = 8'hae;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  // in3 mask bit per output (out4..out1); the in6 mask bit sits one above
  localparam logic [11:0] PG_IN3_BIT_TABLE = {3'h2, 3'h6, 3'h4, 3'h0};
  localparam int PG_OUTPUTS = 4;
  localparam int TERM_DISCHARGE_BIT = 4;

  // auxiliary rail control register layout, msb first
  typedef struct packed {
    logic [1:0] aux_discharge_sel;
    logic aux_shutdown_cfg;
    logic [3:0] aux_voltage_code;
    logic aux_rail_enable;
  } aux_rail_ctrl_t;

  // factory-programmed settings, presented by the nonvolatile store
  typedef struct packed {
    logic [7:0] ctl_input_pg_mask;
    logic [7:0] termination_discharge_ctrl;
    aux_rail_ctrl_t aux_rail_ctrl;
    logic [1:0] shutdown_time_sel;
    logic aux_in_sequence;
    logic switches_merged;
    logic fixed_target_b2;
  } factory_cfg_t;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int MS_IN_NS = 1000000;
  localparam int MS_CYCLES = MS_IN_NS / CLOCK_PERIOD_NS;
  // shutdown hold times in ms for codes 3..0
  localparam logic [27:0] SDWN_MS_TABLE = {7'h64, 7'h0a, 7'h05, 7'h01};

  // ****************************************
  // serial interface
  // ****************************************
  localparam logic [6:0] DEVICE_ADDRESS = 7'h2a; // arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

// >>> power_good_mask_and_rail_ctrl.sv
// power-good mask and auxiliary rail control registers behind the serial port
// assumes factory settings are stable while reset is high and that
// control inputs, member good flags and the shutdown request are synchronous.
// all outputs are registered; the registers are only reached through the serial port,
// which is a separate module; this file holds the registers and what they drive.
//
// Overview of operation
// - mask bits 7/6 drop input six/three from output three's good tree
// - mask bits 5/4 drop input six/three from output two's good tree
// - mask bits 3/2 drop input six/three from output four's good tree
// - mask bits 1/0 drop input six/three from output one's good tree
// - termination discharge bit 4: 0 none, 1 a 100 ohm path
// - shutdown config 0: rail goes off in emergency for factory 1/5/10/100 ms
// - shutdown config 1: rail ignores emergency and follows enable only
// - target is switch b2 if aux sequenced and switches unmerged, else factory
// - aux bits 4:1 carry the regulator output voltage code
// - aux bit 0 enables the selected rail when set
// - a masked tree member is ignored completely
`timescale 1ns/100ps
module power_good_mask_and_rail_ctrl #(
  parameter int MS_TICK_CYCLES = pg_rail_pkg::MS_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire pg_rail_pkg::factory_cfg_t i_factory,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_control_input_three,
  input wire logic i_control_input_six,
  input wire logic [3:0] i_pg_members,
  input wire logic i_emergency_shutdown,
  output logic o_sda_out,
  output logic o_sda_drive_n,
  output logic [3:0] o_pg_output,
  output logic o_termination_discharge_sel,
  output logic [1:0] o_aux_discharge_sel,
  output logic [3:0] o_aux_voltage_code,
  output logic o_aux_regulator_enable,
  output logic o_load_switch_b2_enable
);
  import pg_rail_pkg::*;

  // the divider counts 0 .. MS_TICK_CYCLES - 1, so this width holds every value
  localparam int TICK_W = $clog2(MS_TICK_CYCLES + 1);

  // host-visible registers, loaded from the factory image at reset
  logic [7:0] mask_ff;
  logic [7:0] term_ff;
  aux_rail_ctrl_t aux_ff;

  // serial port side
  logic wr_stb;
  logic [7:0] reg_addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic drive_n;

  // shutdown hold timer; seven bits reach the longest 100 ms entry
  logic [TICK_W-1:0] tick_cnt_ff;
  logic ms_tick_ff;
  logic [6:0] hold_ms_ff;

  // rail steering
  logic target_b2;
  logic rail_on;

  // ****************************************
  // serial register port
  // ****************************************
  // the port owns the register pointer; strobe, pointer and write data
  // come straight from its flip-flops, and reads see the pointed register
  serial_reg_port u_port (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_rdata(rdata),
    .o_wr_stb(wr_stb),
    .o_reg_addr(reg_addr),
    .o_wdata(wdata),
    .o_sda_drive_n(drive_n)
  );

  // open-drain data line: only ever pulls low
  // the extra stage keeps the pin on a flip-flop; acks reach the wire one cycle later
  // o_sda_out stays low: the pin is only ever released or pulled down
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_sda_out <= 1'b0;
      o_sda_drive_n <= 1'b1;
    end else begin
      o_sda_out <= 1'b0;
      o_sda_drive_n <= drive_n;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  // reset loads the factory image, not a fixed constant
  // a write lands one cycle after the strobe; outputs follow one cycle after that
  // writes to unmapped offsets are acknowledged on the wire but change nothing
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mask_ff <= i_factory.ctl_input_pg_mask;
      term_ff <= i_factory.termination_discharge_ctrl;
      aux_ff <= i_factory.aux_rail_ctrl;
    end else if (wr_stb) begin
      unique case (reg_addr)
        CTL_INPUT_PG_MASK_OFS: mask_ff <= wdata;
        // reserved bits are stored as written; the host keeps them at factory values
        TERMINATION_DISCHARGE_CTRL_OFS: term_ff <= wdata;
        AUX_RAIL_CTRL_OFS: aux_ff <= wdata;
        default: ; // writes elsewhere are dropped
      endcase
    end
  end

  // read mux; unmapped offsets read as zero
  // the port samples it only on serial clock falls, so a combinational mux is safe
  always_comb begin
    unique case (reg_addr)
      CTL_INPUT_PG_MASK_OFS: rdata = mask_ff;
      TERMINATION_DISCHARGE_CTRL_OFS: rdata = term_ff;
      AUX_RAIL_CTRL_OFS: rdata = aux_ff;
      default: rdata = UNMAPPED_READ_VALUE;
    endcase
  end

  // ****************************************
  // power-good trees
  // ****************************************
  // a set mask bit forces that member to look good so it cannot hold the output low
  // i_pg_members carries the rest of each tree, already reduced to one flag
  for (genvar g = 0; g < PG_OUTPUTS; g++) begin : g_pg
    localparam logic [2:0] IN3_BIT = PG_IN3_BIT_TABLE[3*g +: 3];
    // the input six mask always sits one bit above the input three mask
    localparam logic [2:0] IN6_BIT = IN3_BIT + 3'h1;
    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        o_pg_output[g] <= 1'b0;
      end else begin
        o_pg_output[g] <= i_pg_members[g]
          & (mask_ff[IN6_BIT] | i_control_input_six)
          & (mask_ff[IN3_BIT] | i_control_input_three);
      end
    end
  end

  // ****************************************
  // discharge and voltage code outputs
  // ****************************************
  // registered copies, so the analog side never sees a half-updated field
  // reserved termination bits have no effect here beyond read-back
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_termination_discharge_sel <= 1'b0;
      o_aux_discharge_sel <= 2'h0;
      o_aux_voltage_code <= 4'h0;
    end else begin
      o_termination_discharge_sel <= term_ff[TERM_DISCHARGE_BIT];
      o_aux_discharge_sel <= aux_ff.aux_discharge_sel;
      o_aux_voltage_code <= aux_ff.aux_voltage_code;
    end
  end

  // ****************************************
  // emergency shutdown hold timer
  // ****************************************
  // millisecond enable pulse; the divider runs free so hold times can be
  // short by up to one ms tick, traded for a single shared counter
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tick_cnt_ff <= '0;
      ms_tick_ff <= 1'b0;
    end else if (tick_cnt_ff == TICK_W'(MS_TICK_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      ms_tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
      ms_tick_ff <= 1'b0;
    end
  end

  // reloads while the request stands, then counts down in ms
  // a held request keeps reloading, so the hold is timed from its release
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hold_ms_ff <= 7'h00;
    end else if (i_emergency_shutdown) begin
      hold_ms_ff <= SDWN_MS_TABLE[7*i_factory.shutdown_time_sel +: 7];
    end else if (ms_tick_ff && hold_ms_ff != 7'h00) begin
      hold_ms_ff <= hold_ms_ff - 7'h01;
    end
  end

  // ****************************************
  // rail enable steering
  // ****************************************
  // target picked by the factory image, read live so it matches the sequencer
  assign target_b2 = (i_factory.aux_in_sequence & ~i_factory.switches_merged)
    | i_factory.fixed_target_b2;

  // a cleared enable always wins; shutdown gates the rail unless told to ignore it
  assign rail_on = aux_ff.aux_rail_enable
    & (aux_ff.aux_shutdown_cfg
       | ~(i_emergency_shutdown | (hold_ms_ff != 7'h00)));

  // both enables come from one process so only the selected rail can ever be on
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_aux_regulator_enable <= 1'b0;
      o_load_switch_b2_enable <= 1'b0;
    end else begin
      o_aux_regulator_enable <= rail_on & ~target_b2;
      o_load_switch_b2_enable <= rail_on & target_b2;
    end
  end

endmodule

// >>> serial_host_model.sv
// host side of the two-wire register bus: start, stop, byte transfers
// assumes the device samples lines one cycle late; each bit holds the clock high four clocks and low five
`timescale 1ns/100ps
module serial_host_model (
  input wire logic i_clock,
  input wire logic i_sda_drive_n,
  output logic o_scl,
  output logic o_sda
);
  // ****************************************
  // wire and bit level
  // ****************************************
  logic sda_host = 1'b1;
  initial o_scl = 1'b1;
  // data line has a pull-up: low whenever either party pulls it
  assign o_sda = sda_host & i_sda_drive_n;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // data changes one cycle after the clock fall so it is never seen as start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_host = b;
    tick(4);
    o_scl = 1'b1;
    tick(3);
    r = o_sda;
    tick(1);
    o_scl = 1'b0;
    tick(1);
  endtask
  task automatic start();
    sda_host = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    sda_host = 1'b0;
    tick(4);
    o_scl = 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda_host = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    sda_host = 1'b1;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask
  // ****************************************
  // register transfers
  // ****************************************
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    put_byte({dev, 1'b0}, a0);
    put_byte(ofs, a1);
    put_byte(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    start();
    put_byte({pg_rail_pkg::DEVICE_ADDRESS, 1'b0}, a);
    put_byte(ofs, a);
    start();
    put_byte({pg_rail_pkg::DEVICE_ADDRESS, 1'b1}, a);
    get_byte(d);
    stop();
  endtask
endmodule

// >>> serial_reg_port.sv
// two-wire serial register port: start/stop detection, address match,
// register pointer with auto-increment, byte writes and byte reads.
// assumes clock and data inputs are already synchronous to i_clock.
`timescale 1ns/100ps
module serial_reg_port (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [7:0] i_rdata,
  output logic o_wr_stb,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_wdata,
  output logic o_sda_drive_n
);
  import pg_rail_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } port_state_t;

  port_state_t state_ff;
  logic scl_ff;
  logic sda_ff;
  logic [7:0] shift_ff;
  logic [3:0] count_ff;
  logic read_ff;
  logic nack_ff;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;

  // ****************************************
  // bus condition detection
  // ****************************************
  // data moving while clock high marks start or stop
  assign start_cond = i_scl & scl_ff & sda_ff & ~i_sda;
  assign stop_cond = i_scl & scl_ff & ~sda_ff & i_sda;
  assign scl_rise = i_scl & ~scl_ff;
  assign scl_fall = ~i_scl & scl_ff;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= i_scl;
      sda_ff <= i_sda;
    end
  end

  // ****************************************
  // protocol sequencer
  // ****************************************
  // changes to the data line happen only after a falling clock edge
  always_ff @(posedge i_clock) begin
    o_wr_stb <= 1'b0;
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      count_ff <= 4'h0;
      read_ff <= 1'b0;
      nack_ff <= 1'b0;
      o_reg_addr <= 8'h00;
      o_wdata <= 8'h00;
      o_sda_drive_n <= 1'b1;
    end else if (start_cond) begin
      state_ff <= ST_ADDR;
      count_ff <= 4'h0;
      o_sda_drive_n <= 1'b1;
    end else if (stop_cond) begin
      state_ff <= ST_IDLE;
      o_sda_drive_n <= 1'b1;
    end else if (scl_rise) begin
      unique case (state_ff)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          shift_ff <= {shift_ff[6:0], i_sda};
          count_ff <= count_ff + 4'h1;
        end
        ST_RDATA: count_ff <= count_ff + 4'h1;
        ST_RDATA_ACK: nack_ff <= i_sda;
        ST_IDLE, ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_ff)
        ST_ADDR: if (count_ff == BITS_PER_BYTE) begin
          count_ff <= 4'h0;
          if (shift_ff[7:1] == DEVICE_ADDRESS) begin
            read_ff <= shift_ff[0];
            o_sda_drive_n <= 1'b0;
            state_ff <= ST_ADDR_ACK;
          end else begin
            state_ff <= ST_IDLE; // not for us: stay off the bus
          end
        end
        ST_PTR, ST_WDATA: if (count_ff == BITS_PER_BYTE) begin
          count_ff <= 4'h0;
          o_sda_drive_n <= 1'b0;
          if (state_ff == ST_PTR) begin
            o_reg_addr <= shift_ff;
            state_ff <= ST_PTR_ACK;
          end else begin
            o_wdata <= shift_ff;
            o_wr_stb <= 1'b1;
            state_ff <= ST_WDATA_ACK;
          end
        end
        ST_ADDR_ACK: begin
          if (read_ff) begin
            shift_ff <= i_rdata;
            o_sda_drive_n <= i_rdata[7];
            state_ff <= ST_RDATA;
          end else begin
            o_sda_drive_n <= 1'b1;
            state_ff <= ST_PTR;
          end
        end
        ST_PTR_ACK: begin
          o_sda_drive_n <= 1'b1;
          state_ff <= ST_WDATA;
        end
        ST_WDATA_ACK: begin
          o_sda_drive_n <= 1'b1;
          o_reg_addr <= o_reg_addr + 8'h01; // burst writes walk upward
          state_ff <= ST_WDATA;
        end
        ST_RDATA: begin
          if (count_ff == BITS_PER_BYTE) begin
            count_ff <= 4'h0;
            o_sda_drive_n <= 1'b1;
            o_reg_addr <= o_reg_addr + 8'h01;
            state_ff <= ST_RDATA_ACK;
          end else begin
            o_sda_drive_n <= shift_ff[6];
            shift_ff <= {shift_ff[6:0], 1'b0};
          end
        end
        ST_RDATA_ACK: begin
          if (nack_ff) begin
            state_ff <= ST_IDLE;
          end else begin
            shift_ff <= i_rdata;
            o_sda_drive_n <= i_rdata[7];
            state_ff <= ST_RDATA;
          end
        end
        ST_IDLE: ;
      endcase
    end
  end

endmodule

// >>> test_power_good_mask_and_rail_ctrl.sv
// self-checking bench for the power-good mask and rail control block
// assumes the host model drives the bus; the ms tick is shortened to 10 clocks
`timescale 1ns/100ps
module test_power_good_mask_and_rail_ctrl;
  import pg_rail_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  logic i_clock, i_sys_rst = 1'b1, ctl_three = 1'b1, ctl_six = 1'b1, estop = 1'b0, scl, sda, sda_out, sda_drive_n;
  logic term, reg_en, b2_en, ok;
  logic [3:0] members = 4'hf, pg, vcode, pg_exp;
  logic [1:0] dis;
  logic [7:0] rd, mval, aval;
  factory_cfg_t fac = '0;
  int num_errors = 0, checks_done = 0, cycles = 0;
  int in3_pos[4] = '{0, 4, 6, 2};
  logic [7:0] masks[4] = '{8'h00, 8'h1b, 8'he4, 8'hff};
  power_good_mask_and_rail_ctrl #(.MS_TICK_CYCLES(10)) i_power_good_mask_and_rail_ctrl (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_factory(fac), .i_scl(scl), .i_sda(sda), .i_control_input_three(ctl_three),
    .i_control_input_six(ctl_six), .i_pg_members(members), .i_emergency_shutdown(estop), .o_sda_out(sda_out),
    .o_sda_drive_n(sda_drive_n), .o_pg_output(pg), .o_termination_discharge_sel(term),
    .o_aux_discharge_sel(dis), .o_aux_voltage_code(vcode), .o_aux_regulator_enable(reg_en),
    .o_load_switch_b2_enable(b2_en));
  serial_host_model i_serial_host_model (.i_clock(i_clock), .i_sda_drive_n(sda_drive_n), .o_scl(scl), .o_sda(sda));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_aux(input aux_rail_ctrl_t a, input logic to_b2);
    chk({6'h0, dis}, {6'h0, a.aux_discharge_sel}, "aux discharge");
    chk({4'h0, vcode}, {4'h0, a.aux_voltage_code}, "aux code");
    chk({6'h0, reg_en, b2_en}, {6'h0, a.aux_rail_enable & ~to_b2, a.aux_rail_enable & to_b2}, "rail enables");
  endtask
  task automatic do_reset(input factory_cfg_t f);
    fac = f;
    i_sys_rst = 1'b1;
    wait_cyc(12);
    i_sys_rst = 1'b0;
    wait_cyc(3);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hang is cut short well beyond the expected run length
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      end_sim();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    do_reset({8'h00, 8'h40, 8'h4b, 2'h1, 3'h4});
    chk({7'h0, term}, 8'h00, "term sel");
    chk_aux(8'h4b, 1'b1);
    chk({7'h0, sda_out}, 8'h00, "sda out level");
    i_serial_host_model.rd_reg(AUX_RAIL_CTRL_OFS, rd);
    chk(rd, 8'h4b, "aux reg");
    $display("test factory load done");
    // asymmetric masks tell every output and both inputs apart
    for (int m = 0; m < 4; m++) begin
      mval = masks[m];
      i_serial_host_model.wr_reg(DEVICE_ADDRESS, CTL_INPUT_PG_MASK_OFS, mval, ok);
      for (int c = 0; c < 4; c++) begin
        ctl_three = c[0];
        ctl_six = c[1];
        wait_cyc(2);
        for (int g = 0; g < 4; g++)
          pg_exp[g] = (c[0] | mval[in3_pos[g]]) & (c[1] | mval[in3_pos[g] + 1]);
        chk({4'h0, pg}, {4'h0, pg_exp}, "pg tree");
      end
    end
    members = 4'h0;
    wait_cyc(2);
    chk({4'h0, pg}, 8'h00, "pg members bad");
    members = 4'hf;
    i_serial_host_model.rd_reg(CTL_INPUT_PG_MASK_OFS, rd);
    chk(rd, 8'hff, "mask reg");
    $display("test mask tree done");
    i_serial_host_model.wr_reg(DEVICE_ADDRESS, TERMINATION_DISCHARGE_CTRL_OFS, 8'h50, ok);
    chk({7'h0, term}, 8'h01, "term sel");
    i_serial_host_model.rd_reg(TERMINATION_DISCHARGE_CTRL_OFS, rd);
    chk(rd, 8'h50, "term reg");
    $display("test termination done");
    for (int d = 0; d < 4; d++) begin
      aval = {d[1:0], 1'b1, 4'(4 * d + 3), d[0]};
      i_serial_host_model.wr_reg(DEVICE_ADDRESS, AUX_RAIL_CTRL_OFS, aval, ok);
      chk_aux(aval, 1'b1);
    end
    estop = 1'b1;
    wait_cyc(6);
    chk({7'h0, b2_en}, 8'h01, "enable ignores shutdown");
    estop = 1'b0;
    i_serial_host_model.wr_reg(DEVICE_ADDRESS, AUX_RAIL_CTRL_OFS, 8'h03, ok);
    estop = 1'b1;
    wait_cyc(2);
    chk({7'h0, b2_en}, 8'h00, "shutdown drop");
    estop = 1'b0;
    wait_cyc(35);
    chk({7'h0, b2_en}, 8'h00, "shutdown hold");
    wait_cyc(20);
    chk({7'h0, b2_en}, 8'h01, "shutdown return");
    $display("test aux rail done");
    i_serial_host_model.wr_reg(DEVICE_ADDRESS, 8'haf, 8'h5a, ok);
    chk({7'h0, ok}, 8'h01, "unmapped ack");
    i_serial_host_model.rd_reg(8'haf, rd);
    chk(rd, UNMAPPED_READ_VALUE, "unmapped read");
    i_serial_host_model.wr_reg(DEVICE_ADDRESS ^ 7'h01, AUX_RAIL_CTRL_OFS, 8'h00, ok);
    chk({7'h0, ok}, 8'h00, "foreign address ack");
    chk_aux(8'h03, 1'b1);
    $display("test refusals done");
    // merged switches keep the regulator as target; longest hold time
    do_reset({8'hff, 8'h40, 8'h21, 2'h3, 3'h6});
    chk_aux(8'h21, 1'b0);
    i_serial_host_model.rd_reg(CTL_INPUT_PG_MASK_OFS, rd);
    chk(rd, 8'hff, "factory mask");
    i_serial_host_model.wr_reg(DEVICE_ADDRESS, AUX_RAIL_CTRL_OFS, 8'h01, ok);
    estop = 1'b1;
    wait_cyc(2);
    chk({7'h0, reg_en}, 8'h00, "regulator shutdown drop");
    estop = 1'b0;
    wait_cyc(980);
    chk({7'h0, reg_en}, 8'h00, "regulator shutdown hold");
    wait_cyc(25);
    chk({7'h0, reg_en}, 8'h01, "regulator shutdown return");
    $display("test second reset done");
    // fixed target with the shortest hold time
    do_reset({8'h00, 8'h40, 8'h01, 2'h0, 3'h1});
    chk_aux(8'h01, 1'b1);
    estop = 1'b1;
    wait_cyc(2);
    chk({7'h0, b2_en}, 8'h00, "short shutdown drop");
    estop = 1'b0;
    wait_cyc(1);
    chk({7'h0, b2_en}, 8'h00, "short shutdown hold");
    wait_cyc(11);
    chk({7'h0, b2_en}, 8'h01, "short shutdown return");
    $display("test fixed target done");
    end_sim();
  end
endmodule
